// ===== inc/uisd_pkg.sv
// Constants for the UART interrupt status and DMA request control block.
// Assumes a 32-bit AHB-Lite register bus and a 16-entry transmit and receive FIFO outside.
package uisd_pkg;

  // Interrupt sources and register widths.
  localparam int unsigned SRC_W    = 11;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned DMA_W    = 3;
  localparam int unsigned BUS_W    = 32;
  localparam int unsigned OFS_W    = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_MASK   = 8'h00;
  localparam logic [7:0] OFS_RAW    = 8'h04;
  localparam logic [7:0] OFS_MASKED = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0C;
  localparam logic [7:0] OFS_DMA    = 8'h10;

  // Status, mask and clear bit positions, identical in all four registers.
  localparam int unsigned BIT_OVERRUN = 10;
  localparam int unsigned BIT_BREAK   = 9;
  localparam int unsigned BIT_PARITY  = 8;
  localparam int unsigned BIT_FRAMING = 7;
  localparam int unsigned BIT_TIMEOUT = 6;
  localparam int unsigned BIT_TX      = 5;
  localparam int unsigned BIT_RX      = 4;
  localparam int unsigned BIT_DSR     = 3;
  localparam int unsigned BIT_DCD     = 2;
  localparam int unsigned BIT_CTS     = 1;
  localparam int unsigned BIT_RING    = 0;
  localparam int unsigned ERR_HI      = 10;
  localparam int unsigned ERR_LO      = 7;

  // DMA control bit positions.
  localparam int unsigned DMA_RX_EN    = 0;
  localparam int unsigned DMA_TX_EN    = 1;
  localparam int unsigned DMA_STOP_ERR = 2;

  // Values after reset.
  localparam logic [SRC_W-1:0] RST_STATUS = 11'h000;
  localparam logic [SRC_W-1:0] RST_MASK   = 11'h000;
  localparam logic [DMA_W-1:0] RST_DMA    = 3'h0;

  // FIFO fill level and trigger selection.
  localparam int unsigned LVL_W = 5;
  localparam int unsigned SEL_W = 3;
  localparam logic [LVL_W-1:0] THR_1_8 = 5'h02;
  localparam logic [LVL_W-1:0] THR_1_4 = 5'h04;
  localparam logic [LVL_W-1:0] THR_1_2 = 5'h08;
  localparam logic [LVL_W-1:0] THR_3_4 = 5'h0C;
  localparam logic [LVL_W-1:0] THR_7_8 = 5'h0E;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ===== inc/uisd_evt_if.sv
// Carrier for the interrupt set events between the event detector and the register block.
// Assumes both ends run on the same register clock.
`timescale 1ns/10ps
interface uisd_evt_if;
  logic [uisd_pkg::SRC_W-1:0] setEvt;
  modport src  (output setEvt);
  modport sink (input  setEvt);
endinterface

// ===== src/uisd_evt_detect.sv
// Turns UART source pulses, FIFO fill levels and modem lines into one-cycle set events.
// Assumes all inputs are synchronous to ref_clk.
`timescale 1ns/10ps
module uisd_evt_detect (
  input  wire logic                      ref_clk,         // Register clock.
  input  wire logic                      reset_n,         // Synchronous reset, low.
  input  wire logic                      overrunIrq,      // Overrun error pulse.
  input  wire logic                      breakIrq,        // Break error pulse.
  input  wire logic                      parityIrq,       // Parity error pulse.
  input  wire logic                      framingIrq,      // Framing error pulse.
  input  wire logic                      rxTimeoutIrq,    // Receive timeout pulse.
  input  wire logic [uisd_pkg::LVL_W-1:0] txFifoLevel,    // Transmit FIFO fill level.
  input  wire logic [uisd_pkg::LVL_W-1:0] rxFifoLevel,    // Receive FIFO fill level.
  input  wire logic [uisd_pkg::SEL_W-1:0] txLevelSel,     // Transmit trigger select.
  input  wire logic [uisd_pkg::SEL_W-1:0] rxLevelSel,     // Receive trigger select.
  input  wire logic                      dataSetReady_n,  // Modem data set ready, low.
  input  wire logic                      carrierDetect_n, // Modem carrier detect, low.
  input  wire logic                      clearToSend_n,   // Modem clear to send, low.
  input  wire logic                      ringIndicator_n, // Modem ring indicator, low.
  uisd_evt_if.src                        evt              // Set events out.
);

  logic [uisd_pkg::LVL_W-1:0] txPrev_q;
  logic [uisd_pkg::LVL_W-1:0] rxPrev_q;
  logic [3:0]                 modemPrev_q;
  logic [3:0]                 modemNow;
  logic [uisd_pkg::LVL_W-1:0] txThr;
  logic [uisd_pkg::LVL_W-1:0] rxThr;
  logic                       txCross;
  logic                       rxCross;

  // Reserved select codes fall back to the half-way mark rather than never triggering.
  function automatic logic [uisd_pkg::LVL_W-1:0] levelThr(input logic [uisd_pkg::SEL_W-1:0] s);
    case (s)
      3'h0:    levelThr = uisd_pkg::THR_1_8;
      3'h1:    levelThr = uisd_pkg::THR_1_4;
      3'h2:    levelThr = uisd_pkg::THR_1_2;
      3'h3:    levelThr = uisd_pkg::THR_3_4;
      3'h4:    levelThr = uisd_pkg::THR_7_8;
      default: levelThr = uisd_pkg::THR_1_2;
    endcase
  endfunction

  assign txThr    = levelThr(txLevelSel);
  assign rxThr    = levelThr(rxLevelSel);
  assign modemNow = {dataSetReady_n, carrierDetect_n, clearToSend_n, ringIndicator_n};

  // Previous levels are loaded during reset too, so release gives no false crossing.
  always_ff @(posedge ref_clk) begin
    txPrev_q    <= txFifoLevel;
    rxPrev_q    <= rxFifoLevel;
    modemPrev_q <= modemNow;
  end

  assign txCross = (txPrev_q > txThr) && (txFifoLevel <= txThr);
  assign rxCross = (rxPrev_q < rxThr) && (rxFifoLevel >= rxThr);

  always_comb begin
    evt.setEvt                        = '0;
    evt.setEvt[uisd_pkg::BIT_OVERRUN] = overrunIrq;
    evt.setEvt[uisd_pkg::BIT_BREAK]   = breakIrq;
    evt.setEvt[uisd_pkg::BIT_PARITY]  = parityIrq;
    evt.setEvt[uisd_pkg::BIT_FRAMING] = framingIrq;
    evt.setEvt[uisd_pkg::BIT_TIMEOUT] = rxTimeoutIrq;
    evt.setEvt[uisd_pkg::BIT_TX]      = txCross;
    evt.setEvt[uisd_pkg::BIT_RX]      = rxCross;
    evt.setEvt[uisd_pkg::BIT_DSR:uisd_pkg::BIT_RING] = (modemNow ^ modemPrev_q) & {4{reset_n}};
  end

endmodule // uisd_evt_detect

// ===== src/uisd_top.sv
// UART interrupt status, interrupt clear and DMA request control with an AHB-Lite slave.
// Assumes a single AHB-Lite master doing word transfers and a DMA controller on the requests.
//
// Contract
// - Raw status is read-only, shows unmasked sources, writes change nothing.
// - Reset clears all status bits 10 to 0, modem bits 3 to 0 included.
// - Raw bits: 10 overrun, 9 break, 8 parity, 7 framing, 6 timeout, 5..0 others.
// - Masked status is read-only, raw state after masking, writes have no effect.
// - Masked status uses the same bit positions as raw status.
// - Clear register is write-only; one clears an interrupt, zero leaves it.
// - Clear bits map exactly like status bits 10 down to 0.
// - Unused DMA control bits 15 to 3 read zero; software writes them unchanged.
// - DMA control is read/write and resets to all zeros.
// - With stop-on-error set, receive DMA requests are held off during an error interrupt.
// - Transmit DMA requests pass only while transmit DMA enable is one.
// - Receive DMA requests pass only while receive DMA enable is one.
// - Mask one passes the raw interrupt to masked status; mask resets to zero.
// - FIFO interrupts fire when the fill level passes through the trigger level.
`timescale 1ns/10ps
module uisd_top (
  input  wire logic                       ref_clk,               // Register clock, 125 MHz.
  input  wire logic                       reset_n,               // Synchronous reset, low.
  // AHB-Lite slave.
  input  wire logic                       hsel,                  // Slave select.
  input  wire logic [uisd_pkg::BUS_W-1:0] haddr,                 // Byte address.
  input  wire logic [1:0]                 htrans,                // Transfer type.
  input  wire logic                       hwrite,                // Write when high.
  input  wire logic [2:0]                 hsize,                 // Transfer size, word only.
  input  wire logic [uisd_pkg::BUS_W-1:0] hwdata,                // Write data.
  input  wire logic                       hready,                // Bus ready in.
  output      logic                       hreadyout,             // Slave ready out.
  output      logic                       hresp,                 // Always OKAY.
  output      logic [uisd_pkg::BUS_W-1:0] hrdata,                // Read data, registered.
  // Interrupt sources.
  input  wire logic                       overrunIrq,            // Overrun error pulse.
  input  wire logic                       breakIrq,              // Break error pulse.
  input  wire logic                       parityIrq,             // Parity error pulse.
  input  wire logic                       framingIrq,            // Framing error pulse.
  input  wire logic                       rxTimeoutIrq,          // Receive timeout pulse.
  input  wire logic [uisd_pkg::LVL_W-1:0] txFifoLevel,           // Transmit FIFO level.
  input  wire logic [uisd_pkg::LVL_W-1:0] rxFifoLevel,           // Receive FIFO level.
  input  wire logic [uisd_pkg::SEL_W-1:0] txLevelSel,            // Transmit trigger select.
  input  wire logic [uisd_pkg::SEL_W-1:0] rxLevelSel,            // Receive trigger select.
  input  wire logic                       dataSetReady_n,        // Modem DSR, low.
  input  wire logic                       carrierDetect_n,       // Modem DCD, low.
  input  wire logic                       clearToSend_n,         // Modem CTS, low.
  input  wire logic                       ringIndicator_n,       // Modem ring, low.
  // Masked interrupt lines toward the interrupt controller.
  output      logic [uisd_pkg::SRC_W-1:0] maskedIrq,             // Masked sources, registered.
  // DMA requests from the FIFO logic and gated requests out.
  input  wire logic                       txFifoSingleReq,       // Raw transmit single.
  input  wire logic                       txFifoBurstReq,        // Raw transmit burst.
  input  wire logic                       rxFifoSingleReq,       // Raw receive single.
  input  wire logic                       rxFifoBurstReq,        // Raw receive burst.
  output      logic                       txDmaSingleRequest,    // Gated transmit single.
  output      logic                       txDmaBurstRequest,     // Gated transmit burst.
  output      logic                       rxDmaSingleRequest,    // Gated receive single.
  output      logic                       rxDmaBurstRequest      // Gated receive burst.
);

  // ---- Source events.

  uisd_evt_if evtBus ();

  uisd_evt_detect u_evt (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .overrunIrq      (overrunIrq),
    .breakIrq        (breakIrq),
    .parityIrq       (parityIrq),
    .framingIrq      (framingIrq),
    .rxTimeoutIrq    (rxTimeoutIrq),
    .txFifoLevel     (txFifoLevel),
    .rxFifoLevel     (rxFifoLevel),
    .txLevelSel      (txLevelSel),
    .rxLevelSel      (rxLevelSel),
    .dataSetReady_n  (dataSetReady_n),
    .carrierDetect_n (carrierDetect_n),
    .clearToSend_n   (clearToSend_n),
    .ringIndicator_n (ringIndicator_n),
    .evt             (evtBus)
  );

  // ---- AHB-Lite slave.

  logic                       addrPhase;
  logic                       phValid_q;
  logic                       phWrite_q;
  logic                       phWord_q;
  logic [uisd_pkg::OFS_W-1:0] phAddr_q;
  logic                       rdWait_q;
  logic [uisd_pkg::BUS_W-1:0] hrdata_q;
  logic                       regWrite;
  logic [uisd_pkg::REG_W-1:0] wrData;
  logic [uisd_pkg::REG_W-1:0] readWord;

  assign addrPhase = hsel && hready && (htrans == uisd_pkg::HTRANS_NONSEQ);

  // Address phase is captured on the edge where the bus is ready.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phValid_q <= 1'b0;
      phWrite_q <= 1'b0;
      phWord_q  <= 1'b0;
      phAddr_q  <= '0;
    end else if (hreadyout) begin
      phValid_q <= addrPhase;
      phWrite_q <= hwrite;
      phWord_q  <= (hsize == 3'h2) && (haddr[1:0] == 2'h0);
      phAddr_q  <= haddr[uisd_pkg::OFS_W-1:0];
    end
  end

  // Reads take one wait state so the returned word reflects a write just before it.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdWait_q <= 1'b0;
    end else if (rdWait_q) begin
      rdWait_q <= 1'b0;
    end else begin
      rdWait_q <= addrPhase && !hwrite;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hrdata_q <= '0;
    end else if (rdWait_q) begin
      hrdata_q <= {16'h0000, readWord};
    end
  end

  assign hreadyout = !rdWait_q;
  assign hresp     = uisd_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_q;

  // Writes commit at the end of a zero-wait data phase; sub-word writes are dropped.
  assign regWrite = phValid_q && phWrite_q && phWord_q;
  assign wrData   = hwdata[uisd_pkg::REG_W-1:0];

  // ---- Registers.

  logic [uisd_pkg::SRC_W-1:0] rawStatus_q;
  logic [uisd_pkg::SRC_W-1:0] mask_q;
  logic [uisd_pkg::DMA_W-1:0] dmaCtrl_q;
  logic [uisd_pkg::SRC_W-1:0] maskedStatus;
  logic [uisd_pkg::SRC_W-1:0] clearHit;
  logic                       errorActive;

  // Only the clear register write produces clear strobes; raw and masked writes do nothing.
  assign clearHit = (regWrite && (phAddr_q == uisd_pkg::OFS_CLEAR)) ?
                    wrData[uisd_pkg::SRC_W-1:0] : '0;

  // Event wins over a clear in the same cycle so no interrupt is lost.
  genvar gi;
  generate
    for (gi = 0; gi < uisd_pkg::SRC_W; gi++) begin : g_raw
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          rawStatus_q[gi] <= uisd_pkg::RST_STATUS[gi];
        end else if (evtBus.setEvt[gi]) begin
          rawStatus_q[gi] <= 1'b1;
        end else if (clearHit[gi]) begin
          rawStatus_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mask_q <= uisd_pkg::RST_MASK;
    end else if (regWrite && (phAddr_q == uisd_pkg::OFS_MASK)) begin
      mask_q <= wrData[uisd_pkg::SRC_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dmaCtrl_q <= uisd_pkg::RST_DMA;
    end else if (regWrite && (phAddr_q == uisd_pkg::OFS_DMA)) begin
      dmaCtrl_q <= wrData[uisd_pkg::DMA_W-1:0];
    end
  end

  assign maskedStatus = rawStatus_q & mask_q;

  always_comb begin
    readWord = '0;
    case (phAddr_q)
      uisd_pkg::OFS_MASK:   readWord = {5'h00, mask_q};
      uisd_pkg::OFS_RAW:    readWord = {5'h00, rawStatus_q};
      uisd_pkg::OFS_MASKED: readWord = {5'h00, maskedStatus};
      uisd_pkg::OFS_DMA:    readWord = {13'h0000, dmaCtrl_q};
      default:              readWord = '0;
    endcase
  end

  // ---- Masked interrupt lines.

  logic [uisd_pkg::SRC_W-1:0] maskedIrq_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      maskedIrq_q <= '0;
    end else begin
      maskedIrq_q <= maskedStatus;
    end
  end

  assign maskedIrq = maskedIrq_q;

  // ---- DMA request gating.

  logic txDmaSingle_q;
  logic txDmaBurst_q;
  logic rxDmaSingle_q;
  logic rxDmaBurst_q;
  logic rxDmaAllow;

  // The error interrupt is the masked OR of overrun, break, parity and framing.
  assign errorActive = |maskedStatus[uisd_pkg::ERR_HI:uisd_pkg::ERR_LO];
  assign rxDmaAllow  = dmaCtrl_q[uisd_pkg::DMA_RX_EN] &&
                       !(dmaCtrl_q[uisd_pkg::DMA_STOP_ERR] && errorActive);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      txDmaSingle_q <= 1'b0;
      txDmaBurst_q  <= 1'b0;
    end else begin
      txDmaSingle_q <= dmaCtrl_q[uisd_pkg::DMA_TX_EN] && txFifoSingleReq;
      txDmaBurst_q  <= dmaCtrl_q[uisd_pkg::DMA_TX_EN] && txFifoBurstReq;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rxDmaSingle_q <= 1'b0;
      rxDmaBurst_q  <= 1'b0;
    end else begin
      rxDmaSingle_q <= rxDmaAllow && rxFifoSingleReq;
      rxDmaBurst_q  <= rxDmaAllow && rxFifoBurstReq;
    end
  end

  assign txDmaSingleRequest = txDmaSingle_q;
  assign txDmaBurstRequest  = txDmaBurst_q;
  assign rxDmaSingleRequest = rxDmaSingle_q;
  assign rxDmaBurstRequest  = rxDmaBurst_q;

endmodule // uisd_top

// ===== bench/uisd_top_props.sv
// Concurrent checks on the ports of the UART interrupt status and DMA request block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module uisd_top_props (
  input wire logic        ref_clk,            // Register clock.
  input wire logic        reset_n,            // Synchronous reset, low.
  input wire logic        hsel,               // Slave select.
  input wire logic [31:0] haddr,              // Byte address.
  input wire logic [1:0]  htrans,             // Transfer type.
  input wire logic        hwrite,             // Write when high.
  input wire logic [2:0]  hsize,              // Transfer size.
  input wire logic [31:0] hwdata,             // Write data.
  input wire logic        hready,             // Bus ready in.
  input wire logic        hreadyout,          // Slave ready out.
  input wire logic [31:0] hrdata,             // Read data.
  input wire logic [10:0] maskedIrq,          // Masked sources.
  input wire logic        txFifoSingleReq,    // Raw transmit single.
  input wire logic        rxFifoBurstReq,     // Raw receive burst.
  input wire logic        txDmaSingleRequest, // Gated transmit single.
  input wire logic        txDmaBurstRequest,  // Gated transmit burst.
  input wire logic        rxDmaSingleRequest, // Gated receive single.
  input wire logic        rxDmaBurstRequest   // Gated receive burst.
);
  wire        addrOk = hsel && hready && htrans == uisd_pkg::HTRANS_NONSEQ;
  wire        rdAddr = addrOk && !hwrite;
  wire        wrAddr = addrOk && hwrite;
  wire        txAny  = txDmaSingleRequest || txDmaBurstRequest;
  wire        rxAny  = rxDmaSingleRequest || rxDmaBurstRequest;
  logic       wrDma_q;
  logic [2:0] dmaShadow_q;

  // Shadow of the DMA control register, updated at the end of the write data phase.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wrDma_q     <= 1'b0;
      dmaShadow_q <= uisd_pkg::RST_DMA;
    end else begin
      wrDma_q <= wrAddr && haddr[7:0] == uisd_pkg::OFS_DMA && hsize == 3'h2 && haddr[1:0] == 2'h0;
      if (wrDma_q) dmaShadow_q <= hwdata[2:0];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_read_wait: assert property (rdAddr |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  a_write_nowait: assert property (wrAddr |=> hreadyout)
    else $error("write data phase stalled");
  a_reserved_zero: assert property (hrdata[31:11] == 21'h00_0000)
    else $error("reserved read bits not zero");
  a_tx_src: assert property (txDmaSingleRequest |-> $past(txFifoSingleReq))
    else $error("transmit request without source");
  a_rx_src: assert property (rxDmaBurstRequest |-> $past(rxFifoBurstReq))
    else $error("receive request without source");
  a_tx_enable: assert property (txAny |-> $past(dmaShadow_q[1]))
    else $error("transmit request while disabled");
  a_rx_enable: assert property (rxAny |-> $past(dmaShadow_q[0]))
    else $error("receive request while disabled");
  a_rx_err_hold: assert property (rxAny |-> !($past(dmaShadow_q[2]) && |maskedIrq[10:7]))
    else $error("receive request during error");
  a_reset_quiet: assert property ($rose(reset_n) |-> maskedIrq == 11'h000 && !txAny && !rxAny)
    else $error("outputs not cleared by reset");

  c_read: cover property (rdAddr);
  c_rx_req: cover property (rxDmaSingleRequest);
  c_ovr_irq: cover property ($rose(maskedIrq[10]));
endmodule // uisd_top_props

bind uisd_top uisd_top_props u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .maskedIrq(maskedIrq), .txFifoSingleReq(txFifoSingleReq),
  .rxFifoBurstReq(rxFifoBurstReq), .txDmaSingleRequest(txDmaSingleRequest),
  .txDmaBurstRequest(txDmaBurstRequest), .rxDmaSingleRequest(rxDmaSingleRequest),
  .rxDmaBurstRequest(rxDmaBurstRequest)
);

// ===== bench/uisd_dma_model.sv
// DMA controller stand-in that records which gated requests it has seen.
// Assumes requests are levels synchronous to ref_clk.
`timescale 1ns/10ps
module uisd_dma_model (
  input  wire logic       ref_clk, // Register clock.
  input  wire logic       reset_n, // Synchronous reset, low.
  input  wire logic       clr,     // Forget what was seen.
  input  wire logic [3:0] req,     // Tx single, tx burst, rx single, rx burst.
  output      logic [3:0] seen     // Sticky record of requests.
);
  // A sticky record catches even a one-cycle request that a spot check would miss.
  always_ff @(posedge ref_clk) begin
    if (!reset_n || clr) seen <= 4'h0;
    else seen <= seen | req;
  end
endmodule // uisd_dma_model

// ===== bench/tb_uart_irq_status_dma_ctrl.sv
// Register-level testbench for the UART interrupt status and DMA request block.
// Assumes a single AHB-Lite master whose hready is the slave's hreadyout.
`timescale 1ns/10ps
module tb_uart_irq_status_dma_ctrl;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [1:0]  htrans  = 2'h0;
  logic [2:0]  hsize   = 3'h2;
  logic [4:0]  err     = 5'h00;
  logic [4:0]  txLvl   = 5'h09;
  logic [4:0]  rxLvl   = 5'h07;
  logic [2:0]  lvlSel  = 3'h2;
  logic [3:0]  modem_n = 4'hF;
  logic [3:0]  rawReq  = 4'hF;
  logic        dmaClr  = 1'b0;
  logic        hreadyout, hresp;
  logic [31:0] hrdata, rd;
  logic [10:0] maskedIrq;
  wire  [3:0]  gated;
  logic [3:0]  seen;
  logic [2:0]  cfg [3] = '{3'h0, 3'h1, 3'h2};
  logic [3:0]  want [3] = '{4'h0, 4'h3, 4'hC};
  int          miscompares = 0;
  int          samples_checked = 0;

  uisd_top DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .overrunIrq(err[4]),
    .breakIrq(err[3]), .parityIrq(err[2]), .framingIrq(err[1]), .rxTimeoutIrq(err[0]),
    .txFifoLevel(txLvl), .rxFifoLevel(rxLvl), .txLevelSel(lvlSel), .rxLevelSel(lvlSel),
    .dataSetReady_n(modem_n[3]), .carrierDetect_n(modem_n[2]), .clearToSend_n(modem_n[1]),
    .ringIndicator_n(modem_n[0]), .maskedIrq(maskedIrq), .txFifoSingleReq(rawReq[3]),
    .txFifoBurstReq(rawReq[2]), .rxFifoSingleReq(rawReq[1]), .rxFifoBurstReq(rawReq[0]),
    .txDmaSingleRequest(gated[3]), .txDmaBurstRequest(gated[2]),
    .rxDmaSingleRequest(gated[1]), .rxDmaBurstRequest(gated[0])
  );

  uisd_dma_model u_dma (.ref_clk(ref_clk), .reset_n(reset_n), .clr(dmaClr), .req(gated),
                        .seen(seen));

  always #4 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Entered right after a rising edge; waits as long as the slave stalls.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= uisd_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, exp, rd);
  endtask

  task automatic pulse(input logic [4:0] e);
    err <= e;
    @(posedge ref_clk);
    err <= 5'h00;
    @(posedge ref_clk);
  endtask

  task automatic dmaChk(input logic [3:0] exp);
    dmaClr <= 1'b1;
    @(posedge ref_clk);
    dmaClr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("dma requests", {28'h000_0000, exp}, {28'h000_0000, seen});
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rdchk("mask", uisd_pkg::OFS_MASK, 32'h0000_0000);
    rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_0000);
    rdchk("masked", uisd_pkg::OFS_MASKED, 32'h0000_0000);
    rdchk("dma", uisd_pkg::OFS_DMA, 32'h0000_0000);
    check("response", {31'h0000_0000, uisd_pkg::HRESP_OKAY}, {31'h0000_0000, hresp});
    $display("Test reset values done");
    pulse(5'h1F);
    rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_07C0);
    bus(1'b1, uisd_pkg::OFS_RAW, 32'h0000_FFFF);
    rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_07C0);
    bus(1'b1, uisd_pkg::OFS_MASK, 32'h0000_0400);
    bus(1'b1, uisd_pkg::OFS_MASKED, 32'h0000_0000);
    rdchk("masked", uisd_pkg::OFS_MASKED, 32'h0000_0400);
    rdchk("mask", uisd_pkg::OFS_MASK, 32'h0000_0400);
    check("masked lines", 32'h0000_0400, {21'h00_0000, maskedIrq});
    $display("Test error events done");
    modem_n <= 4'h0;
    txLvl   <= 5'h08;
    rxLvl   <= 5'h08;
    repeat (3) @(posedge ref_clk);
    rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_07FF);
    bus(1'b1, uisd_pkg::OFS_CLEAR, 32'h0000_0000);
    rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_07FF);
    for (int i = 10; i >= 0; i--) begin
      bus(1'b1, uisd_pkg::OFS_CLEAR, 32'h0000_0001 << i);
      rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_07FF >> (11 - i));
    end
    // Lowest trigger code: transmit falls onto the mark, receive climbs onto it a cycle later.
    lvlSel <= 3'h0;
    txLvl  <= 5'h02;
    rxLvl  <= 5'h01;
    @(posedge ref_clk);
    rxLvl  <= 5'h02;
    @(posedge ref_clk);
    rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_0030);
    bus(1'b1, uisd_pkg::OFS_CLEAR, 32'h0000_0030);
    rdchk("raw", uisd_pkg::OFS_RAW, 32'h0000_0000);
    $display("Test clear done");
    // Upper control bits are written as zero, the value they read back as.
    bus(1'b1, uisd_pkg::OFS_DMA, 32'h0000_0007);
    rdchk("dma", uisd_pkg::OFS_DMA, 32'h0000_0007);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, uisd_pkg::OFS_DMA, {29'h0000_0000, cfg[k]});
      dmaChk(want[k]);
    end
    // Only some raw requests up, so a gate that ignores its source would show.
    rawReq <= 4'h5;
    bus(1'b1, uisd_pkg::OFS_DMA, 32'h0000_0003);
    dmaChk(4'h5);
    rawReq <= 4'hA;
    dmaChk(4'hA);
    rawReq <= 4'hF;
    pulse(5'h10);
    bus(1'b1, uisd_pkg::OFS_DMA, 32'h0000_0005);
    dmaChk(4'h0);
    bus(1'b1, uisd_pkg::OFS_CLEAR, 32'h0000_0400);
    dmaChk(4'h3);
    $display("Test dma gating done");
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
endmodule // tb_uart_irq_status_dma_ctrl
